// File: logic/lti_top.sv
// line threshold interrupt: wishbone register slave, sticky crossing flag,
// event status with mask, and the interrupt pin.
// assumes a classic wishbone master and readings synchronous to clock.
//
// Contract
// - software programs 8-bit threshold used for compare
// - select bit picks loop current or voltage
// - compare uses absolute value of reading
// - direction zero triggers below the threshold
// - direction one triggers above the threshold
// - crossing sets control bit 3 flag
// - flag stays until software writes zero
// - pin needs flag, mask and global enable; the code also needs event status and event mask set
// - masked crossing sets flag, pin stays low
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps

module lti_top (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // wishbone slave
  input wire lti_pkg::lti_wb_req_t wb_req,
  output lti_pkg::lti_wb_rsp_t wb_rsp,
  // line readings
  input wire lti_pkg::lti_meas_t meas,
  // interrupt
  output logic interrupt_output_pin
);

  // ----------------------------------------------------------------
  // state and decode
  // ----------------------------------------------------------------
  lti_pkg::lti_state_t state;
  lti_pkg::lti_state_t next_state;
  logic req_on;
  logic commit;
  logic wr_lane;
  logic [5:0] idx;
  logic [7:0] wdat;
  logic [7:0] magnitude;
  logic hit;
  logic flag_clear;
  logic status_read;

  // request qualifiers; commit is the edge at which master sees ack
  assign req_on = wb_req.cyc & wb_req.stb;
  assign commit = req_on & (state.phase == lti_pkg::lti_bus_ack);
  assign wr_lane = wb_req.we & wb_req.sel[0];
  assign idx = wb_req.adr[7:2];
  assign wdat = wb_req.dat[7:0];

  // zero written to the flag bit of the control register
  assign flag_clear = commit & wr_lane & (idx == lti_pkg::LTI_IDX_CTRL)
                      & ~wdat[lti_pkg::LTI_CTRL_FLAG];

  // a status read clears only the bit that it returned, so an event
  // that lands between data capture and ack is kept for the next read
  assign status_read = commit & ~wb_req.we
                       & (idx == lti_pkg::LTI_IDX_EVT_STATUS)
                       & state.rdata[lti_pkg::LTI_EVT_CROSS];

  // ----------------------------------------------------------------
  // comparator
  // ----------------------------------------------------------------
  lti_compare u_compare (
    .meas(meas),
    .source_select(state.source_select),
    .compare_direction(state.compare_direction),
    .threshold_level(state.threshold_level),
    .magnitude(magnitude),
    .hit(hit)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // read mux; unused upper bits and unmapped words read zero
  function automatic logic [7:0] read_mux(
    input lti_pkg::lti_state_t s,
    input logic [5:0] i
  );
    logic [7:0] v;
    v = 8'h00;
    case (i)
      lti_pkg::LTI_IDX_LEVEL:
      begin
        v = s.threshold_level;
      end
      lti_pkg::LTI_IDX_CTRL:
      begin
        v[lti_pkg::LTI_CTRL_DIR] = s.compare_direction;
        v[lti_pkg::LTI_CTRL_MASK] = s.crossing_mask;
        v[lti_pkg::LTI_CTRL_SEL] = s.source_select;
        v[lti_pkg::LTI_CTRL_FLAG] = s.crossing_flag;
      end
      lti_pkg::LTI_IDX_GIE:
      begin
        v[lti_pkg::LTI_GIE_BIT] = s.global_interrupt_enable;
      end
      lti_pkg::LTI_IDX_EVT_STATUS:
      begin
        v[lti_pkg::LTI_EVT_CROSS] = s.event_status;
      end
      lti_pkg::LTI_IDX_EVT_MASK:
      begin
        v[lti_pkg::LTI_EVT_CROSS] = s.event_mask;
      end
      default:
      begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction : read_mux

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // bus phase, register writes, flag and event updates
  always_comb
  begin
    next_state = state;
    case (state.phase)
      lti_pkg::lti_bus_idle:
      begin
        if (req_on)
        begin
          next_state.phase = lti_pkg::lti_bus_ack;
          next_state.rdata = read_mux(state, idx);
        end
      end
      lti_pkg::lti_bus_ack:
      begin
        next_state.phase = lti_pkg::lti_bus_idle;
      end
      default:
      begin
        next_state.phase = lti_pkg::lti_bus_idle;
      end
    endcase
    // writes land at the edge where ack is seen high
    if (commit & wr_lane)
    begin
      case (idx)
        lti_pkg::LTI_IDX_LEVEL:
        begin
          next_state.threshold_level = wdat;
        end
        lti_pkg::LTI_IDX_CTRL:
        begin
          next_state.compare_direction = wdat[lti_pkg::LTI_CTRL_DIR];
          next_state.crossing_mask = wdat[lti_pkg::LTI_CTRL_MASK];
          next_state.source_select = wdat[lti_pkg::LTI_CTRL_SEL];
        end
        lti_pkg::LTI_IDX_GIE:
        begin
          next_state.global_interrupt_enable = wdat[lti_pkg::LTI_GIE_BIT];
        end
        lti_pkg::LTI_IDX_EVT_MASK:
        begin
          next_state.event_mask = wdat[lti_pkg::LTI_EVT_CROSS];
        end
        default:
        begin
          next_state.event_mask = state.event_mask;
        end
      endcase
    end
    // flag: a zero write clears, a crossing sets, the set wins
    if (flag_clear)
    begin
      next_state.crossing_flag = 1'h0;
    end
    if (hit)
    begin
      next_state.crossing_flag = 1'h1;
    end
    // event status: read clears, a new flag rise sets, the set wins
    if (status_read)
    begin
      next_state.event_status = 1'h0;
    end
    if (hit & ~state.crossing_flag)
    begin
      next_state.event_status = 1'h1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // all control state resets to its constant
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= lti_pkg::LTI_STATE_RST;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // bus answer; upper data bits read zero
  assign wb_rsp.ack = (state.phase == lti_pkg::lti_bus_ack);
  assign wb_rsp.dat = {24'h000000, state.rdata};

  // pin needs flag, mask, global enable and a pending unmasked event
  assign interrupt_output_pin = state.global_interrupt_enable
                                & state.crossing_mask
                                & state.crossing_flag
                                & state.event_status
                                & state.event_mask;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_level_write: assert property (
    @(posedge clock) disable iff (!nrst)
    (commit & wr_lane & (idx == lti_pkg::LTI_IDX_LEVEL))
    |=> (state.threshold_level == $past(wb_req.dat[7:0])))
  else $error("threshold level not stored");

  chk_source_pick: assert property (
    @(posedge clock) disable iff (!nrst)
    (!state.source_select && !meas.loop_current_reading[7])
    |-> (magnitude == meas.loop_current_reading))
  else $error("loop current not selected");

  chk_abs_value: assert property (
    @(posedge clock) disable iff (!nrst)
    (state.source_select && meas.line_voltage_reading[7])
    |-> (magnitude == 8'(~meas.line_voltage_reading + 8'h01)))
  else $error("line voltage magnitude wrong");

  chk_below_sets: assert property (
    @(posedge clock) disable iff (!nrst)
    (!state.compare_direction && (magnitude < state.threshold_level))
    |=> state.crossing_flag)
  else $error("falling crossing missed");

  chk_above_sets: assert property (
    @(posedge clock) disable iff (!nrst)
    (state.compare_direction && (magnitude > state.threshold_level))
    |=> state.crossing_flag)
  else $error("rising crossing missed");

  chk_flag_cause: assert property (
    @(posedge clock) disable iff (!nrst)
    $rose(state.crossing_flag) |-> $past(hit))
  else $error("flag rose without crossing");

  chk_flag_sticky: assert property (
    @(posedge clock) disable iff (!nrst)
    (state.crossing_flag && !flag_clear) |=> state.crossing_flag)
  else $error("flag dropped without zero write");

  chk_pin_gated: assert property (
    @(posedge clock) disable iff (!nrst)
    interrupt_output_pin
    |-> (state.crossing_flag && state.crossing_mask
         && state.global_interrupt_enable))
  else $error("pin high without flag, mask and enable");

  chk_masked_quiet: assert property (
    @(posedge clock) disable iff (!nrst)
    (!state.crossing_mask && hit
     && !(commit && wr_lane && (idx == lti_pkg::LTI_IDX_CTRL)))
    |=> (state.crossing_flag && !interrupt_output_pin))
  else $error("masked crossing misbehaved");

  chk_clear_drops: assert property (
    @(posedge clock) disable iff (!nrst)
    (flag_clear && !hit) |=> !interrupt_output_pin)
  else $error("pin stayed high after clear");

  chk_ack_single: assert property (
    @(posedge clock) disable iff (!nrst)
    wb_rsp.ack |=> !wb_rsp.ack)
  else $error("ack held longer than one cycle");

endmodule : lti_top

// File: shared/lti_pkg.sv
// shared constants, register map and carrier types of the line threshold
// interrupt block.
// assumes a 32-bit classic wishbone bus with byte addresses on adr.

package lti_pkg;

  // ----------------------------------------------------------------
  // register map: word index, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int unsigned LTI_ADR_W = 8;
  localparam int unsigned LTI_IDX_W = 6;
  localparam logic [5:0] LTI_IDX_LEVEL = 6'h2B;
  localparam logic [5:0] LTI_IDX_CTRL = 6'h2C;
  localparam logic [5:0] LTI_IDX_GIE = 6'h38;
  localparam logic [5:0] LTI_IDX_EVT_STATUS = 6'h39;
  localparam logic [5:0] LTI_IDX_EVT_MASK = 6'h3A;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned LTI_CTRL_DIR = 0;
  localparam int unsigned LTI_CTRL_MASK = 1;
  localparam int unsigned LTI_CTRL_SEL = 2;
  localparam int unsigned LTI_CTRL_FLAG = 3;
  localparam int unsigned LTI_GIE_BIT = 0;
  localparam int unsigned LTI_EVT_CROSS = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LTI_LEVEL_RST = 8'h00;
  localparam logic [7:0] LTI_RDATA_RST = 8'h00;
  localparam logic LTI_BIT_RST = 1'h0;
  localparam logic LTI_EVT_MASK_RST = 1'h1;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } lti_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } lti_wb_rsp_t;

  // signed two's complement line readings
  typedef struct packed {
    logic [7:0] loop_current_reading;
    logic [7:0] line_voltage_reading;
  } lti_meas_t;

  typedef enum logic [0:0] {lti_bus_idle, lti_bus_ack} lti_bus_phase_t;

  typedef struct packed {
    lti_bus_phase_t phase;
    logic [7:0] rdata;
    logic [7:0] threshold_level;
    logic compare_direction;
    logic crossing_mask;
    logic source_select;
    logic crossing_flag;
    logic global_interrupt_enable;
    logic event_status;
    logic event_mask;
  } lti_state_t;

  localparam lti_state_t LTI_STATE_RST = '{
    phase: lti_bus_idle,
    rdata: LTI_RDATA_RST,
    threshold_level: LTI_LEVEL_RST,
    compare_direction: LTI_BIT_RST,
    crossing_mask: LTI_BIT_RST,
    source_select: LTI_BIT_RST,
    crossing_flag: LTI_BIT_RST,
    global_interrupt_enable: LTI_BIT_RST,
    event_status: LTI_BIT_RST,
    event_mask: LTI_EVT_MASK_RST
  };

endpackage : lti_pkg

// File: logic/lti_compare.sv
// magnitude compare of the selected line reading against the threshold.
// assumes readings are signed two's complement and stable per clock.
`timescale 1ns/10ps

module lti_compare (
  // line readings
  input wire lti_pkg::lti_meas_t meas,
  // settings
  input wire logic source_select,
  input wire logic compare_direction,
  input wire logic [7:0] threshold_level,
  // results
  output logic [7:0] magnitude,
  output logic hit
);

  // ----------------------------------------------------------------
  // operand pick and absolute value
  // ----------------------------------------------------------------
  logic [7:0] raw;

  // zero picks loop current, one picks line voltage
  assign raw = source_select ? meas.line_voltage_reading
                             : meas.loop_current_reading;

  // minus 128 maps to 8'h80, which is 128 unsigned, so no bit is lost
  assign magnitude = raw[7] ? (~raw + 8'h01) : raw;

  // ----------------------------------------------------------------
  // direction
  // ----------------------------------------------------------------
  // below the level when zero, above it when one
  always_comb
  begin
    if (compare_direction)
    begin
      hit = magnitude > threshold_level;
    end
    else
    begin
      hit = magnitude < threshold_level;
    end
  end

endmodule : lti_compare

// File: testbench/line_threshold_interrupt_tb.sv
// self-checking bench of the line threshold interrupt block.
// assumes lti_top with its package; the bench drives all ports itself.
`timescale 1ns/10ps

`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
    end \
  end

module line_threshold_interrupt_tb;
  // ----------------------------------------------------------------
  // signals and bookkeeping
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dat;
    logic pin;
  } lti_note_t;
  logic clock;
  logic nrst;
  lti_pkg::lti_wb_req_t wb_req;
  lti_pkg::lti_wb_rsp_t wb_rsp;
  lti_pkg::lti_meas_t meas;
  logic interrupt_output_pin;
  lti_note_t notes[$];
  lti_note_t note;
  int fail_count;
  int compares;
  logic [7:0] lvl;
  logic [7:0] r;
  logic [8:0] mag;
  logic s, m, d, g, hit, prev_hit;
  logic [7:0] prev_lvl;
  logic prev_d;
  logic trans;

  lti_top DUT (
    .clock(clock),
    .nrst(nrst),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .meas(meas),
    .interrupt_output_pin(interrupt_output_pin)
  );

  // 50 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic w, input logic [5:0] idx,
                     input logic [7:0] wd);
    int n;
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: {idx, 2'b00},
                sel: 4'hF, dat: {24'h000000, wd}};
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (wb_rsp.ack !== 1'b1 && n < 20);
    wb_req <= '0;
    if (wb_rsp.ack !== 1'b1)
    begin
      fail_count++;
      $display("unexpected at %0t: no ack", $time);
      end_of_test();
    end
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd);
  endtask : wr

  // read with the expected data and pin level noted first
  task automatic rd(input logic [5:0] idx, input logic [7:0] ed,
                    input logic ep);
    notes.push_back('{dat: ed, pin: ep});
    bus(1'b0, idx, 8'h00);
  endtask : rd

  // monitor: each read answer is matched to the oldest note
  always @(posedge clock)
  begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0)
    begin
      if (notes.size() != 0)
        note = notes.pop_front();
      else
        note = 'x;
      `CHK(wb_rsp.dat, {24'h000000, note.dat})
      `CHK(interrupt_output_pin, note.pin)
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    wb_req = '0;
    meas = '0;
    fail_count = 0;
    compares = 0;
    prev_hit = 1'b0;
    prev_lvl = 8'h00;
    prev_d = 1'b0;
    trans = 1'b0;
    void'($urandom(85));
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    // reset values and an unmapped address
    rd(lti_pkg::LTI_IDX_LEVEL, 8'h00, 1'b0);
    rd(lti_pkg::LTI_IDX_CTRL, 8'h00, 1'b0);
    rd(lti_pkg::LTI_IDX_EVT_MASK, 8'h01, 1'b0);
    wr(6'h10, 8'hFF);
    rd(6'h10, 8'h00, 1'b0);
    rd(lti_pkg::LTI_IDX_LEVEL, 8'h00, 1'b0);
    $display("test reset values done");
    // random threshold, source, direction, mask and enable
    for (int i = 0; i < 24; i++)
    begin
      lvl = 8'($urandom % 129);
      s = 1'($urandom);
      m = 1'($urandom);
      d = 1'($urandom);
      g = 1'($urandom);
      // new reading meets the old level and direction until it is rewritten
      trans = prev_d ? (lvl > prev_lvl) : (lvl < prev_lvl);
      meas <= '{loop_current_reading: lvl, line_voltage_reading: lvl};
      wr(lti_pkg::LTI_IDX_LEVEL, lvl);
      wr(lti_pkg::LTI_IDX_GIE, {7'h00, g});
      wr(lti_pkg::LTI_IDX_CTRL, {4'hF, 1'b0, s, m, d});
      rd(lti_pkg::LTI_IDX_EVT_STATUS, {7'h00, prev_hit | trans}, 1'b0);
      r = 8'($urandom);
      meas.loop_current_reading <= s ? ~r : r;
      meas.line_voltage_reading <= s ? r : ~r;
      mag = r[7] ? 9'h100 - {1'b0, r} : {1'b0, r};
      hit = d ? (mag > {1'b0, lvl}) : (mag < {1'b0, lvl});
      repeat (2) @(posedge clock);
      rd(lti_pkg::LTI_IDX_CTRL, {4'h0, hit, s, m, d}, hit & m & g);
      meas <= '{loop_current_reading: lvl, line_voltage_reading: lvl};
      wr(lti_pkg::LTI_IDX_CTRL, {4'h0, 1'b1, s, m, d});
      rd(lti_pkg::LTI_IDX_CTRL, {4'h0, hit, s, m, d}, hit & m & g);
      wr(lti_pkg::LTI_IDX_CTRL, {4'h0, 1'b0, s, m, d});
      rd(lti_pkg::LTI_IDX_CTRL, {4'h0, 1'b0, s, m, d}, 1'b0);
      prev_hit = hit;
      prev_lvl = lvl;
      prev_d = d;
    end
    $display("test threshold crossings done");
    // global enable read back, event mask write and read back
    rd(lti_pkg::LTI_IDX_GIE, {7'h00, g}, 1'b0);
    wr(lti_pkg::LTI_IDX_EVT_MASK, 8'h00);
    rd(lti_pkg::LTI_IDX_EVT_MASK, 8'h00, 1'b0);
    $display("test mask registers done");
    repeat (3) @(posedge clock);
    end_of_test();
  end
endmodule : line_threshold_interrupt_tb
